/* common/pmtr_pkg.sv */
// Constants and types for the program store with table read and serial link.
// Contract
// - Program store holds 4096 sixteen-bit words.
// - Reset sets program counter to word zero.
// - Fetch uses PC; table reads use pointer.
// - Table address is high pointer over low; last-page ops use LAST_PAGE over low instead.
// - Low program byte goes to data memory.
// - High program byte replaces table-high latch.
// - Standard ops sector 0; extended any sector.
// - Software may read and write table-high latch.
// - Every table operation takes two instruction cycles.
// - Programming moves data serially, writer drives clock.
// - Debug uses one data line, clock input.
// - Debug disables alternate functions on both lines.
// - Debug lines double as programming lines.
package pmtr_pkg;
	// ==========================================================
	// Store geometry
	localparam int          PM_WORDS      = 4096;
	localparam int          PM_AW         = 12;
	localparam int          PM_DW         = 16;
	localparam int          PAGE_AW       = 8;
	localparam logic [11:0] RESET_VECTOR  = 12'h000;
	localparam logic [3:0]  LAST_PAGE     = 4'hF;
	localparam int          DM_AW         = 9;

	// ==========================================================
	// Timing counts
	localparam int          CLKS_PER_INSTR = 4;
	localparam int          TBL_INSTR      = 2;
	localparam int          TBL_CLKS       = CLKS_PER_INSTR * TBL_INSTR;
	localparam logic [3:0]  TBL_LAST       = 4'(TBL_CLKS - 1);
	localparam logic [4:0]  LINK_ADDR_LAST = 5'(PM_AW - 1);
	localparam logic [4:0]  LINK_TURN_LAST = 5'h03;
	localparam logic [4:0]  LINK_DATA_LAST = 5'(PM_DW - 1);

	// ==========================================================
	// Table operation codes
	typedef enum logic [1:0] {
		OP_STD      = 2'h0,
		OP_LAST     = 2'h1,
		OP_EXT_LAST = 2'h3,
		OP_EXT      = 2'h2
	} pmtr_op_t;

	// Serial link phases
	typedef enum logic [1:0] {
		LK_CMD  = 2'h0,
		LK_ADDR = 2'h1,
		LK_TURN = 2'h3,
		LK_DATA = 2'h2
	} pmtr_link_t;
endpackage : pmtr_pkg

/* rtl/pmtr_program_memory_table_read.sv */
// Program store with fetch, table read and serial programming/debug link.
module pmtr_program_memory_table_read
	import pmtr_pkg::*;
#(
	parameter int WORDS = PM_WORDS
)(
	// System clock and reset
	input  wire logic                mclk,
	input  wire logic                rst,
	// Instruction fetch
	input  wire logic                fetch_next,
	input  wire logic                pc_load,
	input  wire logic [PM_AW-1:0]    pc_load_addr,
	output logic      [PM_AW-1:0]    pc_q,
	output logic      [PM_DW-1:0]    instr_q,
	output logic                     fetch_hold_q,
	// Table read request
	input  wire logic                tbl_start,
	input  wire logic [1:0]          tbl_op,
	input  wire logic [7:0]          tbl_ptr_low,
	input  wire logic [7:0]          tbl_ptr_high,
	input  wire logic [DM_AW-1:0]    tbl_dest,
	output logic                     tbl_busy_q,
	output logic                     dm_wr_q,
	output logic      [DM_AW-1:0]    dm_addr_q,
	output logic      [7:0]          dm_data_q,
	// Table-high latch software access
	input  wire logic                table_high_byte_latch_wr,
	input  wire logic [7:0]          table_high_byte_latch_wdata,
	output logic      [7:0]          table_high_byte_latch_q,
	// Mode pins
	input  wire logic                prog_mode,
	input  wire logic                debug_mode,
	output logic                     port_a_bit_zero_alt_en_q,
	output logic                     port_a_bit_two_alt_en_q,
	// Shared serial pins
	input  wire logic                programming_serial_clock,
	input  wire logic                programming_serial_data_in,
	output logic                     programming_serial_data_out_q,
	output logic                     programming_serial_data_oe_n_q
);

	// ==========================================================
	// Storage
	// No reset on the array: contents survive only through programming
	logic [PM_DW-1:0] mem [WORDS];

	// ==========================================================
	// Mode synchronisers into mclk
	logic prog_s1_q;
	logic prog_s2_q;
	logic dbg_s1_q;
	logic dbg_s2_q;
	logic link_on;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			prog_s1_q <= 1'b0;
			prog_s2_q <= 1'b0;
			dbg_s1_q  <= 1'b0;
			dbg_s2_q  <= 1'b0;
		end
		else
		begin
			prog_s1_q <= prog_mode;
			prog_s2_q <= prog_s1_q;
			dbg_s1_q  <= debug_mode;
			dbg_s2_q  <= dbg_s1_q;
		end
	end

	// Debug and programming share one engine on the same pair
	assign link_on = prog_s2_q | dbg_s2_q;

	// Alternate pin functions are silenced whenever the pair is claimed;
	// the core is also held off a store that is being rewritten
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			port_a_bit_zero_alt_en_q <= 1'b0;
			port_a_bit_two_alt_en_q  <= 1'b0;
			fetch_hold_q             <= 1'b0;
		end
		else
		begin
			port_a_bit_zero_alt_en_q <= ~link_on;
			port_a_bit_two_alt_en_q  <= ~link_on;
			fetch_hold_q             <= prog_s2_q;
		end
	end

	// ==========================================================
	// Program counter and fetch
	always_ff @(posedge mclk)
	begin
		if (rst)
			pc_q <= RESET_VECTOR;
		else if (pc_load)
			pc_q <= pc_load_addr;
		else if (fetch_next)
			pc_q <= pc_q + 12'h001;
	end

	// Word at the counter, one cycle behind it
	always_ff @(posedge mclk)
	begin
		if (rst)
			instr_q <= 16'h0000;
		else
			instr_q <= mem[pc_q];
	end

	// ==========================================================
	// Table read engine
	logic [PM_AW-1:0] tbl_addr_d;
	logic [PM_AW-1:0] tbl_addr_q;
	logic [DM_AW-1:0] tbl_dest_d;
	logic [3:0]       tbl_cnt_q;
	logic             tbl_done;
	logic [PM_DW-1:0] tbl_word;

	// Address and destination formed from the operation code
	always_comb
	begin
		tbl_addr_d = {tbl_ptr_high[3:0], tbl_ptr_low};
		tbl_dest_d = tbl_dest;
		unique case (pmtr_op_t'(tbl_op))
			OP_STD:
				tbl_dest_d = {1'b0, tbl_dest[7:0]};
			OP_LAST:
			begin
				tbl_addr_d = {LAST_PAGE, tbl_ptr_low};
				tbl_dest_d = {1'b0, tbl_dest[7:0]};
			end
			OP_EXT:
				tbl_dest_d = tbl_dest;
			OP_EXT_LAST:
				tbl_addr_d = {LAST_PAGE, tbl_ptr_low};
		endcase
	end

	assign tbl_done = tbl_busy_q && (tbl_cnt_q == TBL_LAST);
	assign tbl_word = mem[tbl_addr_q];

	// Busy spans exactly two instruction cycles; new starts ignored meanwhile
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tbl_busy_q <= 1'b0;
			tbl_cnt_q  <= 4'h0;
			tbl_addr_q <= 12'h000;
			dm_addr_q  <= 9'h000;
		end
		else if (!tbl_busy_q && tbl_start)
		begin
			tbl_busy_q <= 1'b1;
			tbl_cnt_q  <= 4'h0;
			tbl_addr_q <= tbl_addr_d;
			dm_addr_q  <= tbl_dest_d;
		end
		else if (tbl_done)
			tbl_busy_q <= 1'b0;
		else if (tbl_busy_q)
			tbl_cnt_q <= tbl_cnt_q + 4'h1;
	end

	// Low byte to data memory as a one-cycle strobe
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dm_wr_q   <= 1'b0;
			dm_data_q <= 8'h00;
		end
		else
		begin
			dm_wr_q <= tbl_done;
			if (tbl_done)
				dm_data_q <= tbl_word[7:0];
		end
	end

	// Hardware update wins over a software write in the same cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
			table_high_byte_latch_q <= 8'h00;
		else if (tbl_done)
			table_high_byte_latch_q <= tbl_word[15:8];
		else if (table_high_byte_latch_wr)
			table_high_byte_latch_q <= table_high_byte_latch_wdata;
	end

	// ==========================================================
	// Link domain, clocked by the writer or debug adapter
	logic             lk_on_s1_q;
	logic             lk_on_s2_q;
	pmtr_link_t       lk_st_q;
	logic [4:0]       lk_cnt_q;
	logic             lk_rd_q;
	logic [PM_AW-1:0] lk_addr_q;
	logic [PM_DW-1:0] lk_sh_q;
	logic [PM_DW-1:0] lk_wword_q;
	logic [PM_AW-1:0] lk_waddr_q;
	logic             lk_wtog_q;
	logic             lk_rtog_q;
	logic [PM_DW-1:0] rd_word_q;

	// Mode level into the link clock; frames restart when it drops
	always_ff @(posedge programming_serial_clock)
	begin
		lk_on_s1_q <= link_on;
		lk_on_s2_q <= lk_on_s1_q;
	end

	// Frame: command bit, 12 address bits, turnaround on reads, 16 data bits
	always_ff @(posedge programming_serial_clock)
	begin
		if (!lk_on_s2_q)
		begin
			lk_st_q  <= LK_CMD;
			lk_cnt_q <= 5'h00;
			lk_rd_q  <= 1'b0;
		end
		else
		begin
			lk_cnt_q <= lk_cnt_q + 5'h01;
			unique case (lk_st_q)
				LK_CMD:
				begin
					lk_rd_q  <= programming_serial_data_in;
					lk_st_q  <= LK_ADDR;
					lk_cnt_q <= 5'h00;
				end
				LK_ADDR:
				begin
					lk_addr_q <= {lk_addr_q[PM_AW-2:0], programming_serial_data_in};
					if (lk_cnt_q == LINK_ADDR_LAST)
					begin
						lk_st_q  <= lk_rd_q ? LK_TURN : LK_DATA;
						lk_cnt_q <= 5'h00;
					end
				end
				LK_TURN:
				begin
					lk_sh_q <= rd_word_q;
					if (lk_cnt_q == LINK_TURN_LAST)
					begin
						lk_st_q  <= LK_DATA;
						lk_cnt_q <= 5'h00;
					end
				end
				LK_DATA:
				begin
					lk_sh_q <= {lk_sh_q[PM_DW-2:0], programming_serial_data_in};
					if (lk_cnt_q == LINK_DATA_LAST)
					begin
						lk_st_q  <= LK_CMD;
						lk_cnt_q <= 5'h00;
					end
				end
			endcase
		end
	end

	// Handshake toggles with held words for the mclk side
	always_ff @(posedge programming_serial_clock)
	begin
		if (!lk_on_s2_q)
		begin
			lk_wtog_q <= 1'b0;
			lk_rtog_q <= 1'b0;
		end
		else if (lk_st_q == LK_ADDR && lk_cnt_q == LINK_ADDR_LAST && lk_rd_q)
			lk_rtog_q <= ~lk_rtog_q;
		else if (lk_st_q == LK_DATA && lk_cnt_q == LINK_DATA_LAST && !lk_rd_q)
		begin
			lk_wtog_q  <= ~lk_wtog_q;
			lk_waddr_q <= lk_addr_q;
			lk_wword_q <= {lk_sh_q[PM_DW-2:0], programming_serial_data_in};
		end
	end

	// Device drives the data line only while returning a read word
	always_ff @(posedge programming_serial_clock)
	begin
		if (!lk_on_s2_q)
		begin
			programming_serial_data_oe_n_q <= 1'b1;
			programming_serial_data_out_q  <= 1'b0;
		end
		else
		begin
			programming_serial_data_oe_n_q <= ~(lk_rd_q && (lk_st_q == LK_TURN
				&& lk_cnt_q == LINK_TURN_LAST || lk_st_q == LK_DATA
				&& lk_cnt_q != LINK_DATA_LAST));
			programming_serial_data_out_q  <= (lk_st_q == LK_TURN) ? rd_word_q[PM_DW-1]
				: lk_sh_q[PM_DW-2];
		end
	end

	// ==========================================================
	// Toggle synchronisers into mclk and store access
	logic [2:0] wtog_q;
	logic [2:0] rtog_q;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wtog_q <= 3'h0;
			rtog_q <= 3'h0;
		end
		else
		begin
			wtog_q <= {wtog_q[1:0], lk_wtog_q};
			rtog_q <= {rtog_q[1:0], lk_rtog_q};
		end
	end

	// Write word lands once the toggle has settled; held fields are stable
	always_ff @(posedge mclk)
	begin
		if (prog_s2_q && (wtog_q[2] != wtog_q[1]))
			mem[lk_waddr_q] <= lk_wword_q;
	end

	// Reloaded long before each turnaround ends, so it needs no reset
	always_ff @(posedge mclk)
	begin
		if (rtog_q[2] != rtog_q[1])
			rd_word_q <= mem[lk_addr_q];
	end

endmodule : pmtr_program_memory_table_read

/* verif/pmtr_checker.sv */
// Concurrent checks on the program store ports.
module pmtr_checker
	import pmtr_pkg::*;
(
	// Clock, reset and fetch
	input wire logic		mclk,
	input wire logic		rst,
	input wire logic		pc_load,
	input wire logic [PM_AW-1:0]	pc_load_addr,
	input wire logic [PM_AW-1:0]	pc_q,
	// Table read
	input wire logic		tbl_start,
	input wire logic [1:0]		tbl_op,
	input wire logic [DM_AW-1:0]	tbl_dest,
	input wire logic		tbl_busy_q,
	input wire logic		dm_wr_q,
	input wire logic [DM_AW-1:0]	dm_addr_q,
	input wire logic		table_high_byte_latch_wr,
	input wire logic [7:0]		table_high_byte_latch_wdata,
	input wire logic [7:0]		table_high_byte_latch_q,
	// Modes
	input wire logic		prog_mode,
	input wire logic		debug_mode,
	input wire logic		port_a_bit_zero_alt_en_q,
	input wire logic		port_a_bit_two_alt_en_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ========
	// Reset must not be masked, it is the cause here
	a_reset_pc: assert property (disable iff (1'b0) rst |=> pc_q == RESET_VECTOR)
		else $error("pc not at reset vector");
	a_fetch_load: assert property (pc_load |=> pc_q == $past(pc_load_addr))
		else $error("pc load missed");
	a_start_busy: assert property (tbl_start && !tbl_busy_q |=> tbl_busy_q)
		else $error("table start not taken");
	a_busy_len: assert property ($rose(tbl_busy_q) |-> tbl_busy_q[*8] ##1 !tbl_busy_q)
		else $error("busy length wrong");
	a_wr_after: assert property ($fell(tbl_busy_q) |-> dm_wr_q)
		else $error("no data write at end");
	a_wr_pulse: assert property (dm_wr_q |=> !dm_wr_q)
		else $error("write pulse too long");
	a_dest_sector: assert property (tbl_start && !tbl_busy_q |=>
		dm_addr_q[8] == ($past(tbl_op[1]) & $past(tbl_dest[8])))
		else $error("destination sector wrong");
	a_latch_sw: assert property (table_high_byte_latch_wr && !tbl_busy_q |=>
		table_high_byte_latch_q == $past(table_high_byte_latch_wdata))
		else $error("latch write lost");
	a_alt_off: assert property ((prog_mode || debug_mode)[*4] |->
		!port_a_bit_zero_alt_en_q && !port_a_bit_two_alt_en_q)
		else $error("alternate function left on");
	// Main scenarios reached
	c_tbl_done: cover property (dm_wr_q);
	c_pc_load: cover property (pc_load);
	c_sw_latch: cover property (table_high_byte_latch_wr);
	c_refused: cover property (tbl_start && tbl_busy_q);
endmodule : pmtr_checker

/* verif/pmtr_writer_model.sv */
// Behavioural serial writer on the shared programming pins.
module pmtr_writer_model (
	// Shared serial pins, far side view
	output logic		programming_serial_clock,
	output logic		programming_serial_data_in,
	input wire logic	programming_serial_data_out_q,
	input wire logic	programming_serial_data_oe_n_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic	drv = 1'b1;
	logic	wbit = 1'b0;
	logic	s;
	// Clock idles low between frames, only the writer drives it
	initial programming_serial_clock = 1'b0;
	// Line level from both drivers; a released line flips to expose stale reads
	assign programming_serial_data_in = !programming_serial_data_oe_n_q ?
		programming_serial_data_out_q : (drv ? wbit : !wbit);
	// One link clock: data set while low, sampled just before the rise
	task automatic bit1(input logic b);
		wbit = b;
		#80 s = programming_serial_data_in;
		programming_serial_clock = 1'b1;
		#80 programming_serial_clock = 1'b0;
	endtask : bit1
	// Command, address MSB first, then data out or turnaround and data in
	task automatic frame(input logic rd, input logic [11:0] a, input logic [15:0] d,
		output logic [15:0] q);
		q = 16'h0000;
		drv = 1'b1;
		bit1(rd);
		for (int i = 11; i >= 0; i--) bit1(a[i]);
		if (!rd)
			for (int i = 15; i >= 0; i--) bit1(d[i]);
		else
		begin
			drv = 1'b0;
			repeat (4) bit1(1'b0);
			for (int i = 15; i >= 0; i--)
			begin
				bit1(1'b0);
				q[i] = s;
			end
			drv = 1'b1;
		end
	endtask : frame
endmodule : pmtr_writer_model

/* verif/tb_program_memory_table_read.sv */
// Self-checking bench for the program store with table read.
module tb_program_memory_table_read;
	import pmtr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, v); end end
	// ========
	logic		mclk = 0, rst = 1, fetch_next = 0, pc_load = 0, tbl_start = 0;
	logic		table_high_byte_latch_wr = 0, prog_mode = 0, debug_mode = 0;
	logic [11:0]	pc_load_addr = 0, pc_q, a;
	logic [15:0]	instr_q, q;
	logic [1:0]	tbl_op = 0, op [8];
	logic [7:0]	tbl_ptr_low = 0, tbl_ptr_high = 0, table_high_byte_latch_wdata = 0, lo [8], hi [8];
	logic [7:0]	dm_data_q, table_high_byte_latch_q;
	logic [8:0]	tbl_dest = 0, dm_addr_q, de [8];
	logic		fetch_hold_q, tbl_busy_q, dm_wr_q;
	logic		port_a_bit_zero_alt_en_q, port_a_bit_two_alt_en_q;
	logic		programming_serial_clock, programming_serial_data_in;
	logic		programming_serial_data_out_q, programming_serial_data_oe_n_q;
	logic [15:0]	mem [logic [11:0]];
	int		err_count = 0, cmp_count = 0;
	pmtr_program_memory_table_read u_pmtr_program_memory_table_read (.*);
	pmtr_writer_model u_wr (.*);
	always #12.5 mclk = ~mclk;
	// Last-page ops ignore the high pointer, which gives only four bits
	function automatic logic [11:0] taddr(input logic [1:0] o, input logic [7:0] l, h);
		return {o[0] ? LAST_PAGE : h[3:0], l};
	endfunction : taddr
	task automatic results();
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	// One table read, timed from start to data write
	task automatic tread(input int k);
		int n;
		logic [15:0] w;
		w = mem[taddr(op[k], lo[k], hi[k])];
		@(negedge mclk);
		{tbl_start, tbl_op, tbl_ptr_low, tbl_ptr_high, tbl_dest} = {1'b1, op[k], lo[k], hi[k], de[k]};
		@(negedge mclk);
		// Odd reads try a restart while busy; it must be ignored
		tbl_ptr_low = ~lo[k];
		tbl_start = k[0];
		n = 0;
		while (dm_wr_q !== 1'b1 && n < 20)
		begin
			@(negedge mclk);
			tbl_start = 1'b0;
			n++;
		end
		`CHK("cycles", 9, n + 1)
		if (n == 20) results();
		`CHK("low byte", w[7:0], dm_data_q)
		`CHK("high byte", w[15:8], table_high_byte_latch_q)
		`CHK("dest", {op[k][1] & de[k][8], de[k][7:0]}, dm_addr_q)
	endtask : tread
	initial
	begin
		void'($urandom(48));
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		for (int k = 0; k < 8; k++)
			{op[k], lo[k], hi[k], de[k]} = {2'(k), 8'($urandom), 8'($urandom), 9'($urandom)};
		{lo[0], hi[0]} = {8'h06, 8'h0F};
		// Link side has no reset: clock it idle with the mode low to clear it
		repeat (3) u_wr.bit1(1'b0);
		@(negedge mclk);
		// Writer loads every table word; the third clock in mode is a command
		prog_mode = 1'b1;
		repeat (2) u_wr.bit1(1'b0);
		`CHK("alt0", 1'b0, port_a_bit_zero_alt_en_q)
		`CHK("hold", 1'b1, fetch_hold_q)
		for (int k = 0; k < 8; k++)
		begin
			a = taddr(op[k], lo[k], hi[k]);
			mem[a] = 16'($urandom);
			u_wr.frame(1'b0, a, mem[a], q);
		end
		u_wr.frame(1'b1, taddr(op[0], lo[0], hi[0]), 16'h0000, q);
		`CHK("readback", mem[taddr(op[0], lo[0], hi[0])], q)
		// The link must see the mode drop before debug claims the pair
		@(negedge mclk);
		prog_mode = 1'b0;
		repeat (3) u_wr.bit1(1'b0);
		// Debug mode shares the same pins and engine
		@(negedge mclk);
		debug_mode = 1'b1;
		repeat (2) u_wr.bit1(1'b0);
		`CHK("hold dbg", 1'b0, fetch_hold_q)
		`CHK("alt2", 1'b0, port_a_bit_two_alt_en_q)
		u_wr.frame(1'b1, taddr(op[7], lo[7], hi[7]), 16'h0000, q);
		`CHK("debug read", mem[taddr(op[7], lo[7], hi[7])], q)
		@(negedge mclk);
		debug_mode = 1'b0;
		repeat (6) @(negedge mclk);
		`CHK("alt back", 1'b1, port_a_bit_zero_alt_en_q)
		// No latch write is interleaved with these reads
		for (int k = 0; k < 8; k++) tread(k);
		// Software write of the latch
		table_high_byte_latch_wr = 1'b1;
		table_high_byte_latch_wdata = 8'($urandom);
		@(negedge mclk);
		table_high_byte_latch_wr = 1'b0;
		`CHK("latch sw", table_high_byte_latch_wdata, table_high_byte_latch_q)
		// Fetch by program counter
		a = taddr(op[1], lo[1], hi[1]);
		{pc_load, pc_load_addr} = {1'b1, a};
		@(negedge mclk);
		pc_load = 1'b0;
		`CHK("pc load", a, pc_q)
		@(negedge mclk);
		`CHK("instr", mem[a], instr_q)
		fetch_next = 1'b1;
		@(negedge mclk);
		fetch_next = 1'b0;
		`CHK("pc next", a + 12'h001, pc_q)
		// Reset in mid-run returns to the vector
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		`CHK("pc reset", 12'h000, pc_q)
		results();
	end
endmodule : tb_program_memory_table_read
bind pmtr_program_memory_table_read pmtr_checker u_chk (.*);
